// ==== mal_alert.sv ====
module mal_alert
  import mal_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [WIDTH-1:0] REG_WDATA_I,
  output logic [WIDTH-1:0] REG_RDATA_O,
  input wire logic CONV_DONE_I,
  input wire logic MATH_OVF_I,
  input wire logic SINGLE_SHOT_I,
  input wire logic CFG_WR_ACTIVE_I,
  input wire logic signed [WIDTH-1:0] SHUNT_I,
  input wire logic signed [WIDTH-1:0] BUS_I,
  input wire logic signed [WIDTH-1:0] POWER_I,
  output logic ALERT_O,
  output logic ALERT_OE_O
);
  logic [WIDTH-1:0] ctrl;
  logic [WIDTH-1:0] thresh;
  logic alert_function_flag;
  logic conversion_done_flag;
  logic math_overflow_flag;
  logic ready_alert;
  logic violated;
  logic status_rd;
  logic status_wr;
  logic alert_active;
  logic next_alert_out;
  logic next_alert_oe;

  assign status_rd = CE_I && REG_RD_I && REG_ADDR_I == MAL_ADDR_SRC_STAT;
  assign status_wr = CE_I && REG_WR_I && REG_ADDR_I == MAL_ADDR_SRC_STAT;

  mal_compare #(
    .WIDTH(WIDTH)
  ) u_cmp (
    .enables_i(ctrl),
    .threshold_i(thresh),
    .shunt_i(SHUNT_I),
    .bus_i(BUS_I),
    .power_i(POWER_I),
    .violated_o(violated)
  );

  // ==========================================================================
  // control and threshold registers
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ctrl <= MAL_RESET_SRC_STAT;
    end else if (status_wr) begin
      ctrl <= REG_WDATA_I & MAL_WR_MASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      thresh <= MAL_RESET_THRESH;
    end else if (CE_I && REG_WR_I && REG_ADDR_I == MAL_ADDR_THRESH) begin
      thresh <= REG_WDATA_I;
    end
  end

  // ==========================================================================
  // alert function flag
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      alert_function_flag <= 1'b0;
    end else if (CE_I) begin
      if (CONV_DONE_I && violated) begin
        alert_function_flag <= 1'b1;
      end else if (ctrl[MAL_BIT_LAT]) begin
        if (status_rd) begin
          alert_function_flag <= 1'b0;
        end
      end else if (CONV_DONE_I) begin
        alert_function_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // conversion done flag
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      conversion_done_flag <= 1'b0;
    end else if (CE_I) begin
      if (CONV_DONE_I) begin
        conversion_done_flag <= 1'b1;
      end else if (SINGLE_SHOT_I && (status_rd || CFG_WR_ACTIVE_I)) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // math overflow flag
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      math_overflow_flag <= 1'b0;
    end else if (CE_I) begin
      if (MATH_OVF_I) begin
        math_overflow_flag <= 1'b1;
      end else if (CONV_DONE_I && !ctrl[MAL_BIT_LAT]) begin
        math_overflow_flag <= 1'b0;
      end else if (status_rd && ctrl[MAL_BIT_LAT]) begin
        math_overflow_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // ready alert, held until a status read or until the conversion done flag clears
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ready_alert <= 1'b0;
    end else if (CE_I) begin
      if (CONV_DONE_I && ctrl[MAL_BIT_RDY]) begin
        ready_alert <= 1'b1;
      end else if (!conversion_done_flag || status_rd) begin
        ready_alert <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // open-collector alert pin
  assign alert_active = alert_function_flag || ready_alert;

  always_comb begin
    // open collector, level fixed low
    next_alert_out = 1'b0;
    next_alert_oe = 1'b0;
    if (ctrl[MAL_BIT_ALERT_OUTPUT_POLARITY]) begin
      next_alert_oe = !alert_active;
    end else begin
      next_alert_oe = alert_active;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ALERT_O <= 1'b0;
      ALERT_OE_O <= 1'b0;
    end else if (CE_I) begin
      ALERT_O <= next_alert_out;
      ALERT_OE_O <= next_alert_oe;
    end
  end

  // ==========================================================================
  // read data
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= '0;
    end else if (CE_I && REG_RD_I) begin
      case (REG_ADDR_I)
        MAL_ADDR_SRC_STAT: begin
          REG_RDATA_O <= ctrl;
          REG_RDATA_O[MAL_BIT_AFF] <= alert_function_flag;
          REG_RDATA_O[MAL_BIT_CDF] <= conversion_done_flag;
          REG_RDATA_O[MAL_BIT_OVF] <= math_overflow_flag;
        end
        MAL_ADDR_THRESH: REG_RDATA_O <= thresh;
        default: REG_RDATA_O <= '0;
      endcase
    end
  end

  // ==========================================================================
  // checks
  property p_ready_alert;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && CONV_DONE_I && ctrl[MAL_BIT_RDY]) |=> alert_active;
  endproperty
  a_ready_alert: assert property (p_ready_alert) else $error("ready alert missing");

  property p_latch_hold;
    @(posedge CLK_I) disable iff (RESET_I)
    (alert_function_flag && ctrl[MAL_BIT_LAT] && !status_rd) |=> alert_function_flag;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped");

  property p_latch_clear;
    @(posedge CLK_I) disable iff (RESET_I)
    (status_rd && ctrl[MAL_BIT_LAT] && !(CONV_DONE_I && violated)) |=> !alert_function_flag;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latched flag kept");

  property p_transp_clear;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && CONV_DONE_I && !violated && !ctrl[MAL_BIT_LAT]) |=> !alert_function_flag;
  endproperty
  a_transp_clear: assert property (p_transp_clear) else $error("flag not cleared");

  property p_done_set;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && CONV_DONE_I) |=> conversion_done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_ovf_set;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && MATH_OVF_I) |=> math_overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

  property p_pol;
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I |=> (ALERT_OE_O == ($past(ctrl[MAL_BIT_ALERT_OUTPUT_POLARITY]) ^ $past(alert_active)));
  endproperty
  a_pol: assert property (p_pol) else $error("alert polarity wrong");

  property p_fn_set;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && CONV_DONE_I && violated) |=> alert_function_flag;
  endproperty
  a_fn_set: assert property (p_fn_set) else $error("alert flag not set");

  property p_single_clear;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !CONV_DONE_I && SINGLE_SHOT_I && status_rd) |=> !conversion_done_flag;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("done flag kept");
endmodule : mal_alert

// ==== mal_pkg.sv ====
// Operation
// - with the ready alert enable set, the alert output asserts whenever the conversion done flag sets.
// - only one limit function drives the alert at a time, and the ready alert may join it.
// - in latch mode the alert function flag clears only on a read of the alert source and status register.
// - in transparent mode the alert function flag clears after the next conversion that does not alert.
// - the conversion done flag sets only after conversions, averaging and multiplications are finished.
// - in single-shot mode the conversion done flag clears on a configuration write that is not power-down, or on a status read.
// - the math overflow flag sets to one when an arithmetic step overflows.
// - the polarity bit selects an active-high alert when one and active-low when zero, the default.
// - the latch bit selects latch mode when one and transparent mode when zero, the default.
// - in transparent mode the alert output and flags go idle after the next conversion that does not alert.
// - in latch mode the alert output and flags stay active until the host reads the status register.
// - the 16-bit threshold is compared with the measurement chosen by the enabled limit function.
// - with several limit functions enabled, only the most significant enabled one counts.
// - the five functions are shunt over, shunt under, bus over, bus under and power over the limit.
package mal_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] MAL_ADDR_SRC_STAT = 8'h06;
  localparam logic [7:0] MAL_ADDR_THRESH = 8'h07;
  localparam logic [15:0] MAL_RESET_SRC_STAT = 16'h0000;
  localparam logic [15:0] MAL_RESET_THRESH = 16'h0000;
  // ==========================================================================
  // field positions
  localparam int MAL_BIT_SOL = 15;
  localparam int MAL_BIT_SUL = 14;
  localparam int MAL_BIT_BOL = 13;
  localparam int MAL_BIT_BUL = 12;
  localparam int MAL_BIT_POL = 11;
  localparam int MAL_BIT_RDY = 10;
  localparam int MAL_BIT_AFF = 4;
  localparam int MAL_BIT_CDF = 3;
  localparam int MAL_BIT_OVF = 2;
  localparam int MAL_BIT_ALERT_OUTPUT_POLARITY = 1;
  localparam int MAL_BIT_LAT = 0;
  localparam logic [15:0] MAL_WR_MASK = 16'hfc03;
  // ==========================================================================
  // limit function selection
  typedef enum logic [2:0] {
    MAL_FN_NONE,
    MAL_FN_SHUNT_OVER,
    MAL_FN_SHUNT_UNDER,
    MAL_FN_BUS_OVER,
    MAL_FN_BUS_UNDER,
    MAL_FN_POWER_OVER
  } mal_fn_e;
endpackage : mal_pkg

// ==== mal_compare.sv ====
module mal_compare
  import mal_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] enables_i,
  input wire logic signed [WIDTH-1:0] threshold_i,
  input wire logic signed [WIDTH-1:0] shunt_i,
  input wire logic signed [WIDTH-1:0] bus_i,
  input wire logic signed [WIDTH-1:0] power_i,
  output logic violated_o
);
  mal_fn_e fn;

  // ==========================================================================
  // priority select
  always_comb begin
    if (enables_i[MAL_BIT_SOL]) begin
      fn = MAL_FN_SHUNT_OVER;
    end else if (enables_i[MAL_BIT_SUL]) begin
      fn = MAL_FN_SHUNT_UNDER;
    end else if (enables_i[MAL_BIT_BOL]) begin
      fn = MAL_FN_BUS_OVER;
    end else if (enables_i[MAL_BIT_BUL]) begin
      fn = MAL_FN_BUS_UNDER;
    end else if (enables_i[MAL_BIT_POL]) begin
      fn = MAL_FN_POWER_OVER;
    end else begin
      fn = MAL_FN_NONE;
    end
  end

  // ==========================================================================
  // comparison
  always_comb begin
    case (fn)
      MAL_FN_SHUNT_OVER: violated_o = shunt_i > threshold_i;
      MAL_FN_SHUNT_UNDER: violated_o = shunt_i < threshold_i;
      MAL_FN_BUS_OVER: violated_o = bus_i > threshold_i;
      MAL_FN_BUS_UNDER: violated_o = bus_i < threshold_i;
      MAL_FN_POWER_OVER: violated_o = power_i > threshold_i;
      default: violated_o = 1'b0;
    endcase
  end
endmodule : mal_compare

// ==== mal_host.sv ====
module mal_host (
  input wire logic alert_i,
  input wire logic alert_oe_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // pull-up on the open-collector alert line
  assign pin_o = alert_oe_i ? alert_i : 1'b1;
endmodule : mal_host

// ==== test_monitor_alert_logic.sv ====
module test_monitor_alert_logic;
  import mal_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic cdone = 1'b0;
  logic ovf = 1'b0;
  logic cfgw = 1'b0;
  logic ce = 1'b1;
  logic ss = 1'b1;
  logic alert;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] sh = 16'h0000;
  logic [15:0] bu = 16'h0000;
  logic [15:0] pw = 16'h0000;
  logic [15:0] t;
  logic [15:0] v;
  logic [15:0] o;
  logic [31:0] ent;
  logic [31:0] expq[$];
  logic [15:0] rdata;
  logic oe;
  logic pin;
  int errors = 0;
  int n_compared = 0;
  int seed = 8611;
  always #25 clk = ~clk;
  mal_alert dut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .CONV_DONE_I(cdone),
    .MATH_OVF_I(ovf), .SINGLE_SHOT_I(ss), .CFG_WR_ACTIVE_I(cfgw), .SHUNT_I(sh), .BUS_I(bu),
    .POWER_I(pw), .ALERT_O(alert), .ALERT_OE_O(oe));
  mal_host host (.alert_i(alert), .alert_oe_i(oe), .pin_o(pin));
  // ==========================================
  // tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back({16'hffff, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task conv(input logic [15:0] s, input logic [15:0] b, input logic [15:0] p);
    @(posedge clk);
    sh <= s;
    bu <= b;
    pw <= p;
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
  endtask : conv
  task oe_is(input logic e);
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, oe}, {15'h0000, e});
  endtask : oe_is
  task test_done;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // ==========================================
  // read data monitor
  always @(posedge clk) begin
    if (rd_seen && expq.size() > 0) begin
      ent = expq.pop_front();
      check(rdata & ent[31:16], ent[15:0]);
    end
    rd_seen <= rd;
  end
  // ==========================================
  // watchdog
  initial begin
    #(50 * 4000);
    errors++;
    test_done();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t = 16'h0100 + 16'($random(seed) & 32'h0fff);
    rreg(MAL_ADDR_SRC_STAT, 16'h0000);
    rreg(MAL_ADDR_THRESH, 16'h0000);
    rreg(8'h08, 16'h0000);
    check({15'h0000, pin}, 16'h0001);
    wreg(MAL_ADDR_THRESH, t);
    rreg(MAL_ADDR_THRESH, t);
    wreg(MAL_ADDR_SRC_STAT, 16'hffff);
    rreg(MAL_ADDR_SRC_STAT, 16'hfc03);
    for (int i = 0; i < 5; i++) begin
      wreg(MAL_ADDR_SRC_STAT, 16'h8000 >> i);
      v = (i % 2 == 0) ? t + 16'd5 : t - 16'd5;
      o = (i % 2 == 0) ? t - 16'd5 : t + 16'd5;
      conv((i < 2) ? v : o, (i == 2 || i == 3) ? v : o, (i == 4) ? v : o);
      oe_is(1'b1);
      conv(o, o, o);
      oe_is(1'b0);
    end
    wreg(MAL_ADDR_SRC_STAT, 16'hc000);
    conv(t - 16'd5, t, t);
    oe_is(1'b0);
    wreg(MAL_ADDR_SRC_STAT, 16'h8001);
    conv(t + 16'd5, t, t);
    oe_is(1'b1);
    conv(t - 16'd5, t, t);
    oe_is(1'b1);
    rreg(MAL_ADDR_SRC_STAT, 16'h8019);
    oe_is(1'b0);
    rreg(MAL_ADDR_SRC_STAT, 16'h8001);
    wreg(MAL_ADDR_SRC_STAT, 16'h8002);
    oe_is(1'b1);
    conv(t + 16'd5, t, t);
    oe_is(1'b0);
    check({15'h0000, pin}, 16'h0001);
    wreg(MAL_ADDR_SRC_STAT, 16'h0400);
    conv(t, t, t);
    oe_is(1'b1);
    @(posedge clk);
    cfgw <= 1'b1;
    @(posedge clk);
    cfgw <= 1'b0;
    oe_is(1'b0);
    conv(t, t, t);
    oe_is(1'b1);
    rreg(MAL_ADDR_SRC_STAT, 16'h0408);
    oe_is(1'b0);
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    rreg(MAL_ADDR_SRC_STAT, 16'h0404);
    // clock enable low: a violating conversion is ignored
    wreg(MAL_ADDR_SRC_STAT, 16'h8000);
    @(posedge clk);
    ce <= 1'b0;
    conv(t + 16'd5, t, t);
    @(posedge clk);
    ce <= 1'b1;
    ss <= 1'b0;
    oe_is(1'b0);
    rreg(MAL_ADDR_SRC_STAT, 16'h8004);
    // continuous mode: status read keeps the done flag
    conv(t - 16'd5, t, t);
    rreg(MAL_ADDR_SRC_STAT, 16'h8008);
    rreg(MAL_ADDR_SRC_STAT, 16'h8008);
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule : test_monitor_alert_logic
